// File: hub_cfg_pkg.sv
package hub_cfg_pkg;

  // ==========================================================================
  // timing
  // cycles after reset release before synchronised pins are trusted
  localparam logic [1:0] CAPTURE_WAIT = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic STRAP_RESET = 1'h0;
  localparam logic MODE_RESET  = 1'h0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ROLE_NONE   = 2'b00,
    ROLE_SLAVE  = 2'b01,
    ROLE_MASTER = 2'b10
  } port_role_t;

  typedef enum logic {
    ST_WAIT = 1'b0,
    ST_RUN  = 1'b1
  } capture_state_t;

  // levels that enter the core clock domain asynchronously
  typedef struct packed {
    logic mode;
    logic scl;
    logic sda;
    logic hs_susp;
    logic ss_susp;
  } core_in_t;

  // open-drain drive requests of one engine
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } od_drive_t;

endpackage

// File: hub_cfg_port.sv
`timescale 1ns/1ps
module hub_cfg_port
  import hub_cfg_pkg::*;
(
  // core clock and reset
  input  wire logic      clock_i,
  input  wire logic      rst_n_i,
  // link clock and reset
  input  wire logic      link_clk_i,
  input  wire logic      link_rst_n_i,
  // mode strap pin
  input  wire logic      serial_port_mode_select_i,
  // shared serial pins, open drain
  input  wire logic      config_serial_clock_pin_i,
  output logic           config_serial_clock_pin_o,
  output logic           config_serial_clock_pin_oe_o,
  input  wire logic      config_serial_data_pin_i,
  output logic           config_serial_data_pin_o,
  output logic           config_serial_data_pin_oe_o,
  // engine side
  input  wire od_drive_t master_drive_i,
  input  wire od_drive_t slave_drive_i,
  output logic           master_sel_o,
  output logic           slave_sel_o,
  output logic           serial_clock_o,
  output logic           serial_data_o,
  output logic           config_valid_o,
  output logic           config_serial_data_strap_o,
  // configuration source
  input  wire logic      config_loaded_i,
  input  wire logic      link_low_power_disable_bit_i,
  // link side, link clock
  input  wire logic      hs_port_suspended_i,
  input  wire logic      ss_port_suspended_i,
  output logic           u1u2_disable_o,
  // status pins
  output logic           high_speed_suspend_flag_o,
  output logic           ss_suspend_flag_o
);

  // ==========================================================================
  // link domain: suspend levels registered, disable decision synchronised in
  logic hs_l_q, hs_l_d;
  logic ss_l_q, ss_l_d;
  logic dis1_q, dis1_d;
  logic dis2_q, dis2_d;
  logic disable_q, disable_d;

  always_comb
  begin
    hs_l_d = hs_port_suspended_i;
    ss_l_d = ss_port_suspended_i;
    dis1_d = disable_q;
    dis2_d = dis1_q;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (!link_rst_n_i)
    begin
      hs_l_q <= 1'h0;
      ss_l_q <= 1'h0;
      dis1_q <= STRAP_RESET;
      dis2_q <= STRAP_RESET;
    end
    else
    begin
      hs_l_q <= hs_l_d;
      ss_l_q <= ss_l_d;
      dis1_q <= dis1_d;
      dis2_q <= dis2_d;
    end
  end

  assign u1u2_disable_o = dis2_q;

  // ==========================================================================
  // core domain: two-flop synchroniser for pins and link levels
  core_in_t sync1_q, sync1_d;
  core_in_t sync2_q, sync2_d;

  always_comb
  begin
    sync1_d = '{mode:    serial_port_mode_select_i,
                scl:     config_serial_clock_pin_i,
                sda:     config_serial_data_pin_i,
                hs_susp: hs_l_q,
                ss_susp: ss_l_q};
    sync2_d = sync1_q;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ==========================================================================
  // strap and mode capture after reset release
  capture_state_t st_q, st_d;
  logic [1:0]     cnt_q, cnt_d;
  logic           mode_q, mode_d;
  logic           strap_q, strap_d;
  logic           valid_q, valid_d;

  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    mode_d  = mode_q;
    strap_d = strap_q;
    valid_d = valid_q;
    case (st_q)
      ST_WAIT:
      begin
        // synchroniser holds reset zeros until it has refilled
        if (cnt_q == CAPTURE_WAIT)
        begin
          st_d    = ST_RUN;
          mode_d  = sync2_q.mode;
          strap_d = sync2_q.sda;
          valid_d = 1'h1;
        end
        else
        begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      ST_RUN:
      begin
        st_d = ST_RUN;
      end
      default:
      begin
        st_d = ST_WAIT;
        valid_d = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      st_q    <= ST_WAIT;
      cnt_q   <= 2'h0;
      mode_q  <= MODE_RESET;
      strap_q <= STRAP_RESET;
      valid_q <= 1'h0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      mode_q  <= mode_d;
      strap_q <= strap_d;
      valid_q <= valid_d;
    end
  end

  // ==========================================================================
  // role routing and status outputs
  port_role_t role_q, role_d;
  logic       scl_oe_q, scl_oe_d;
  logic       sda_oe_q, sda_oe_d;
  logic       scl_q, scl_d;
  logic       sda_q, sda_d;
  logic       hs_q, hs_d;
  logic       ss_q, ss_d;
  logic       master_sel_q, master_sel_d;
  logic       slave_sel_q, slave_sel_d;

  always_comb
  begin
    role_d   = ROLE_NONE;
    scl_oe_d = 1'h0;
    sda_oe_d = 1'h0;
    if (st_q == ST_RUN)
    begin
      role_d = mode_q ? ROLE_MASTER : ROLE_SLAVE;
    end
    // select outputs registered alongside the role, so they match it cycle for cycle
    master_sel_d = (role_d == ROLE_MASTER);
    slave_sel_d  = (role_d == ROLE_SLAVE);
    case (role_q)
      ROLE_MASTER:
      begin
        scl_oe_d = master_drive_i.scl_oe;
        sda_oe_d = master_drive_i.sda_oe;
      end
      ROLE_SLAVE:
      begin
        scl_oe_d = slave_drive_i.scl_oe;
        sda_oe_d = slave_drive_i.sda_oe;
      end
      default:
      begin
        scl_oe_d = 1'h0;
        sda_oe_d = 1'h0;
      end
    endcase
    scl_d = sync2_q.scl;
    sda_d = sync2_q.sda;
    // loaded configuration outranks the pin strap
    if (st_q == ST_RUN && config_loaded_i)
    begin
      disable_d = link_low_power_disable_bit_i;
    end
    else
    begin
      disable_d = strap_q;
    end
    hs_d = sync2_q.hs_susp;
    ss_d = sync2_q.ss_susp;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      role_q    <= ROLE_NONE;
      scl_oe_q  <= 1'h0;
      sda_oe_q  <= 1'h0;
      scl_q     <= 1'h0;
      sda_q     <= 1'h0;
      disable_q <= STRAP_RESET;
      hs_q      <= 1'h0;
      ss_q      <= 1'h0;
      master_sel_q <= 1'h0;
      slave_sel_q  <= 1'h0;
    end
    else
    begin
      role_q    <= role_d;
      scl_oe_q  <= scl_oe_d;
      sda_oe_q  <= sda_oe_d;
      scl_q     <= scl_d;
      sda_q     <= sda_d;
      disable_q <= disable_d;
      hs_q      <= hs_d;
      ss_q      <= ss_d;
      master_sel_q <= master_sel_d;
      slave_sel_q  <= slave_sel_d;
    end
  end

  // open drain: only ever pull low, release otherwise
  assign config_serial_clock_pin_o    = 1'h0;
  assign config_serial_data_pin_o     = 1'h0;
  assign config_serial_clock_pin_oe_o = scl_oe_q;
  assign config_serial_data_pin_oe_o  = sda_oe_q;
  assign master_sel_o                 = master_sel_q;
  assign slave_sel_o                  = slave_sel_q;
  assign serial_clock_o               = scl_q;
  assign serial_data_o                = sda_q;
  assign config_valid_o               = valid_q;
  assign config_serial_data_strap_o   = strap_q;
  assign high_speed_suspend_flag_o    = hs_q;
  assign ss_suspend_flag_o            = ss_q;

endmodule

// File: hub_cfg_port_monitor.sv
`timescale 1ns/1ps
module hub_cfg_port_monitor
  import hub_cfg_pkg::*;
(
  // core clock and reset
  input wire logic      clock_i,
  input wire logic      rst_n_i,
  // pins and engine drives
  input wire logic      config_serial_data_pin_i,
  input wire od_drive_t master_drive_i,
  input wire od_drive_t slave_drive_i,
  input wire logic      config_serial_clock_pin_oe_o,
  input wire logic      config_serial_data_pin_oe_o,
  // role and strap
  input wire logic      master_sel_o,
  input wire logic      slave_sel_o,
  input wire logic      config_valid_o,
  input wire logic      config_serial_data_strap_o,
  // low-power decision
  input wire logic      config_loaded_i,
  input wire logic      link_low_power_disable_bit_i,
  input wire logic      u1u2_disable_o,
  // suspend status
  input wire logic      hs_port_suspended_i,
  input wire logic      ss_port_suspended_i,
  input wire logic      high_speed_suspend_flag_o,
  input wire logic      ss_suspend_flag_o
);
  // ==========================================================================
  // checks, link outputs sampled as levels after settling
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_master_route: assert property (
    master_sel_o |=>
      {config_serial_clock_pin_oe_o, config_serial_data_pin_oe_o} == $past(master_drive_i))
    else $error("route");
  a_unsel_idle: assert property (
    !master_sel_o && !slave_sel_o |=>
      !config_serial_clock_pin_oe_o && !config_serial_data_pin_oe_o)
    else $error("idle");
  a_slave_route: assert property (
    slave_sel_o |=>
      {config_serial_clock_pin_oe_o, config_serial_data_pin_oe_o} == $past(slave_drive_i))
    else $error("route");
  a_strap_caught: assert property (
    $rose(config_valid_o) |-> config_serial_data_strap_o == $past(config_serial_data_pin_i, 3))
    else $error("strap");
  a_state_hold: assert property (
    $past(config_valid_o, 2) |-> $stable(master_sel_o) && $stable(config_serial_data_strap_o))
    else $error("hold");
  a_strap_u1u2: assert property (
    (config_valid_o && !config_loaded_i)[*8] |-> u1u2_disable_o == config_serial_data_strap_o)
    else $error("u1u2");
  a_cfg_u1u2: assert property (
    (config_loaded_i && config_valid_o && $stable(link_low_power_disable_bit_i))[*8]
    |-> u1u2_disable_o == link_low_power_disable_bit_i) else $error("u1u2");
  a_hs_flag: assert property (
    $stable(hs_port_suspended_i)[*7] |-> high_speed_suspend_flag_o == hs_port_suspended_i)
    else $error("hs");
  a_ss_flag: assert property (
    $stable(ss_port_suspended_i)[*7] |-> ss_suspend_flag_o == ss_port_suspended_i)
    else $error("ss");
  c_master: cover property ($rose(master_sel_o));
  c_slave: cover property ($rose(slave_sel_o));
  c_u1u2: cover property ($rose(u1u2_disable_o));
  c_loaded: cover property ($rose(config_loaded_i && config_valid_o));
endmodule

bind hub_cfg_port hub_cfg_port_monitor hub_cfg_port_monitor_inst (
  .clock_i                      (clock_i),
  .rst_n_i                      (rst_n_i),
  .config_serial_data_pin_i     (config_serial_data_pin_i),
  .master_drive_i               (master_drive_i),
  .slave_drive_i                (slave_drive_i),
  .config_serial_clock_pin_oe_o (config_serial_clock_pin_oe_o),
  .config_serial_data_pin_oe_o  (config_serial_data_pin_oe_o),
  .master_sel_o                 (master_sel_o),
  .slave_sel_o                  (slave_sel_o),
  .config_valid_o               (config_valid_o),
  .config_serial_data_strap_o   (config_serial_data_strap_o),
  .config_loaded_i              (config_loaded_i),
  .link_low_power_disable_bit_i (link_low_power_disable_bit_i),
  .u1u2_disable_o               (u1u2_disable_o),
  .hs_port_suspended_i          (hs_port_suspended_i),
  .ss_port_suspended_i          (ss_port_suspended_i),
  .high_speed_suspend_flag_o    (high_speed_suspend_flag_o),
  .ss_suspend_flag_o            (ss_suspend_flag_o)
);

// File: hub_cfg_partner.sv
`timescale 1ns/1ps
module hub_cfg_partner
(
  // board pull-up and far side drive
  input  wire logic pull_up_i,
  input  wire logic host_low_i,
  // hub open-drain enables
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  // wire levels
  output logic      scl_o,
  output logic      sda_o
);
  // no pull-up fitted: the pin pull-down holds both wires low
  assign scl_o = pull_up_i & ~host_low_i & ~scl_oe_i;
  assign sda_o = pull_up_i & ~host_low_i & ~sda_oe_i;
endmodule

// File: hub_cfg_port_test.sv
`timescale 1ns/1ps
module hub_cfg_port_test;
  import hub_cfg_pkg::*;
  logic      clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, mode = 1'b0, pull = 1'b0, low = 1'b0;
  logic      ld = 1'b0, dbit = 1'b0, hs = 1'b0, ss = 1'b0;
  od_drive_t md = '0, sd = '0;
  logic      scl, sda, c_oe, d_oe, ms, ssl, sc, sdt, vld, strap, u1u2, hsf, ssf;
  int        fail_count = 0, checks_done = 0, cycles = 0;

  // ==========================================================================
  // clocks, design and far side
  initial forever #5 clk = ~clk;
  initial #3 forever #7.5 lclk = ~lclk;
  hub_cfg_port hub_cfg_port_inst (.clock_i(clk), .rst_n_i(rst_n), .link_clk_i(lclk),
    .link_rst_n_i(rst_n), .serial_port_mode_select_i(mode), .config_serial_clock_pin_i(scl),
    .config_serial_clock_pin_o(), .config_serial_clock_pin_oe_o(c_oe),
    .config_serial_data_pin_i(sda), .config_serial_data_pin_o(),
    .config_serial_data_pin_oe_o(d_oe), .master_drive_i(md), .slave_drive_i(sd),
    .master_sel_o(ms), .slave_sel_o(ssl), .serial_clock_o(sc), .serial_data_o(sdt),
    .config_valid_o(vld), .config_serial_data_strap_o(strap), .config_loaded_i(ld),
    .link_low_power_disable_bit_i(dbit), .hs_port_suspended_i(hs), .ss_port_suspended_i(ss),
    .u1u2_disable_o(u1u2), .high_speed_suspend_flag_o(hsf), .ss_suspend_flag_o(ssf));
  hub_cfg_partner hub_cfg_partner_inst (.pull_up_i(pull), .host_low_i(low), .scl_oe_i(c_oe),
    .sda_oe_i(d_oe), .scl_o(scl), .sda_o(sda));

  // ==========================================================================
  // tasks
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // ==========================================================================
  // sequence: every mode and strap level, each after a fresh reset
  initial
  begin
    for (int t = 0; t < 4; t++)
    begin
      rst_n = 1'b0;
      mode = t[0];
      pull = t[1];
      low = 1'b0;
      ld = 1'b0;
      md = '0;
      sd = '0;
      cyc(20);
      chk({vld, ms | ssl}, 2'h0);
      rst_n = 1'b1;
      cyc(8);
      chk({ms, ssl}, {t[0], !t[0]});
      chk(strap, t[1]);
      chk(vld, 1'b1);
      cyc(10);
      chk(u1u2, t[1]);
      chk({sc, sdt}, {t[1], t[1]});
      mode = !mode;
      low = 1'b1;
      md.sda_oe = 1'b1;
      sd.scl_oe = 1'b1;
      cyc(6);
      chk({ms, strap}, {t[0], t[1]});
      chk({c_oe, d_oe}, {!t[0], t[0]});
      chk({sc, sdt}, 2'h0);
      ld = 1'b1;
      dbit = !t[1];
      cyc(10);
      chk(u1u2, !t[1]);
      $display("test %0d done", t);
    end
    for (int s = 0; s < 4; s++)
    begin
      @(negedge lclk);
      hs = s[0];
      ss = s[1];
      cyc(10);
      chk({hsf, ssf}, {s[0], s[1]});
    end
    $display("suspend test done");
    end_sim();
  end
endmodule
